// ---- scs_pkg.sv ----
package scs_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ        = 250;
    localparam int STEP_NS        = 500;
    localparam int STEP_CYC       = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int CLK_STOP_US    = 12;
    localparam int CLK_STOP_CYC   = CLK_STOP_US * CLK_MHZ;
    localparam int GATE_WIN_US    = 200;
    localparam int GATE_WIN_CYC   = GATE_WIN_US * CLK_MHZ;
    localparam int DEBOUNCE_MS    = 8;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * 1000 * CLK_MHZ;
    localparam int SUPPLY_OFF_CYC = STEP_CYC;
    localparam int CNT_W          = 24;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        SCS_IDLE,
        SCS_RAMP,
        SCS_LINES,
        SCS_CLOCK,
        SCS_ACTIVE,
        SCS_DRST,
        SCS_DCLK,
        SCS_DLINES,
        SCS_DOFF
    } scs_state_t;

    // Divider select codes
    localparam logic [1:0] DIV_8 = 2'h0;
    localparam logic [1:0] DIV_4 = 2'h1;
    localparam logic [1:0] DIV_1 = 2'h2;
    localparam logic [1:0] DIV_2 = 2'h3;
endpackage

// ---- scs_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
    parameter int DEBOUNCE_CYCLES = scs_pkg::DEBOUNCE_CYC,
    parameter int GATE_CYCLES     = scs_pkg::GATE_WIN_CYC,
    parameter int STOP_CYCLES     = scs_pkg::CLK_STOP_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic interface_clock_in,
    input  wire logic session_request_n,
    input  wire logic host_reset_request,
    input  wire logic card_detect_in,
    input  wire logic detect_active_high,
    input  wire logic divider_select_hi,
    input  wire logic divider_select_lo,
    input  wire logic supply_good,
    input  wire logic host_uv_fault,
    input  wire logic supply_fault,
    input  wire logic regulator_input_supply,
    input  wire logic over_temp,
    input  wire logic host_data_in,
    input  wire logic host_aux_one_in,
    input  wire logic host_aux_two_in,
    input  wire logic card_data_in,
    input  wire logic card_aux_one_in,
    input  wire logic card_aux_two_in,
    output logic      flag_n,
    output logic      card_supply_out,
    output logic      card_clock_out,
    output logic      card_reset_out,
    output logic      host_data_out,
    output logic      host_data_oe,
    output logic      host_aux_one_out,
    output logic      host_aux_one_oe,
    output logic      host_aux_two_out,
    output logic      host_aux_two_oe,
    output logic      card_data_out,
    output logic      card_data_oe,
    output logic      card_aux_one_out,
    output logic      card_aux_one_oe,
    output logic      card_aux_two_out,
    output logic      card_aux_two_oe
);
    localparam int NS = 13;

    initial begin
        if (DEBOUNCE_CYCLES < 2 || DEBOUNCE_CYCLES >= (1 << scs_pkg::CNT_W) ||
            GATE_CYCLES < 2 || GATE_CYCLES >= (1 << scs_pkg::CNT_W) ||
            STOP_CYCLES < 2 || STOP_CYCLES >= (1 << scs_pkg::CNT_W)) begin
            $error("scs_sequencer: count parameter out of range");
        end
    end

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [NS-1:0] meta_r;
    logic [NS-1:0] sync_r;
    logic [NS-1:0] raw_in;
    assign raw_in = {interface_clock_in, session_request_n, host_reset_request, card_detect_in,
                     supply_good, host_uv_fault, supply_fault, regulator_input_supply, over_temp,
                     host_data_in, card_data_in, host_aux_one_in, card_aux_one_in};

    // Two flops on every outside input except detect_active_high and the divider selects
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= raw_in;
            sync_r <= meta_r;
        end
    end

    logic [1:0] aux2_meta_r;
    logic [1:0] aux2_sync_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux2_meta_r <= 2'h3;
            aux2_sync_r <= 2'h3;
        end else begin
            aux2_meta_r <= {host_aux_two_in, card_aux_two_in};
            aux2_sync_r <= aux2_meta_r;
        end
    end

    logic s_iclk, s_sess_n, s_host_reset_request, s_det, s_good, s_uv, s_sfault, s_regulator_input_supply, s_hot;
    logic s_hd, s_cd, s_ha1, s_ca1;
    assign {s_iclk, s_sess_n, s_host_reset_request, s_det, s_good, s_uv, s_sfault, s_regulator_input_supply, s_hot,
            s_hd, s_cd, s_ha1, s_ca1} = sync_r;

    // Rising edge of interface clock, timing tick
    logic iclk_d_r;
    logic tick;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) iclk_d_r <= 1'b0;
        else        iclk_d_r <= s_iclk;
    end
    assign tick = s_iclk & ~iclk_d_r;

    // ************************************************************
    // Presence and debounce
    // ************************************************************
    logic card_in;
    assign card_in = s_det ~^ detect_active_high;

    logic [scs_pkg::CNT_W-1:0] deb_cnt_r;
    logic                      present_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            deb_cnt_r <= '0;
            present_r <= 1'b0;
        end else if (!card_in) begin
            deb_cnt_r <= '0;
            present_r <= 1'b0;
        end else if (!present_r && tick) begin
            if (deb_cnt_r == scs_pkg::CNT_W'(DEBOUNCE_CYCLES - 1)) present_r <= 1'b1;
            else deb_cnt_r <= deb_cnt_r + 1'b1;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    scs_pkg::scs_state_t       st_r;
    logic [scs_pkg::CNT_W-1:0] cnt_r;
    logic [scs_pkg::CNT_W-1:0] win_r;
    logic                      gated_r;
    logic                      clk_run_r;
    logic                      rst_mirror_r;
    logic                      fault;
    logic                      sess_ok;
    // Current-limit events have no input here: never reported
    assign fault   = !present_r | s_uv | s_sfault | !s_regulator_input_supply | s_hot;
    assign sess_ok = !s_sess_n && !fault;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r    <= scs_pkg::SCS_IDLE;
            cnt_r   <= '0;
            gated_r <= 1'b0;
        end else begin
            case (st_r)
                scs_pkg::SCS_IDLE: begin
                    cnt_r <= '0;
                    if (sess_ok) begin
                        gated_r <= s_host_reset_request;
                        st_r    <= scs_pkg::SCS_RAMP;
                    end
                end
                scs_pkg::SCS_RAMP: begin
                    if (!sess_ok) st_r <= scs_pkg::SCS_DRST;
                    else if (s_good) st_r <= scs_pkg::SCS_LINES;
                end
                scs_pkg::SCS_LINES: begin
                    if (!sess_ok) st_r <= scs_pkg::SCS_DRST;
                    else if (tick) begin
                        if (cnt_r == scs_pkg::CNT_W'(scs_pkg::STEP_CYC - 1)) begin
                            cnt_r <= '0;
                            st_r  <= scs_pkg::SCS_CLOCK;
                        end else cnt_r <= cnt_r + 1'b1;
                    end
                end
                scs_pkg::SCS_CLOCK: begin
                    if (!sess_ok) st_r <= scs_pkg::SCS_DRST;
                    else if (tick) begin
                        if (cnt_r == scs_pkg::CNT_W'(scs_pkg::STEP_CYC - 1)) begin
                            cnt_r <= '0;
                            st_r  <= scs_pkg::SCS_ACTIVE;
                        end else cnt_r <= cnt_r + 1'b1;
                    end
                end
                scs_pkg::SCS_ACTIVE: begin
                    cnt_r <= '0;
                    if (!sess_ok) st_r <= scs_pkg::SCS_DRST;
                end
                scs_pkg::SCS_DRST: begin
                    if (tick) begin
                        if (cnt_r == scs_pkg::CNT_W'(STOP_CYCLES - 1)) begin
                            cnt_r <= '0;
                            st_r  <= scs_pkg::SCS_DCLK;
                        end else cnt_r <= cnt_r + 1'b1;
                    end
                end
                scs_pkg::SCS_DCLK: st_r <= scs_pkg::SCS_DLINES;
                scs_pkg::SCS_DLINES: begin
                    if (tick) begin
                        if (cnt_r == scs_pkg::CNT_W'(scs_pkg::SUPPLY_OFF_CYC - 1)) begin
                            cnt_r <= '0;
                            st_r  <= scs_pkg::SCS_DOFF;
                        end else cnt_r <= cnt_r + 1'b1;
                    end
                end
                scs_pkg::SCS_DOFF: begin
                    if (!s_good && s_sess_n) st_r <= scs_pkg::SCS_IDLE;
                end
                default: st_r <= scs_pkg::SCS_IDLE;
            endcase
        end
    end

    // Window counter from start of activation
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) win_r <= '0;
        else if (st_r == scs_pkg::SCS_IDLE) win_r <= '0;
        else if (tick && win_r != scs_pkg::CNT_W'(GATE_CYCLES)) win_r <= win_r + 1'b1;
    end

    logic in_act;
    logic win_done;
    assign in_act   = (st_r == scs_pkg::SCS_CLOCK) || (st_r == scs_pkg::SCS_ACTIVE);
    assign win_done = (win_r == scs_pkg::CNT_W'(GATE_CYCLES));

    logic clk_zone;
    logic stop_end;
    assign clk_zone = (st_r == scs_pkg::SCS_LINES) || in_act;
    assign stop_end = (cnt_r == scs_pkg::CNT_W'(STOP_CYCLES - 1));

    // Clock run and reset mirror per mode
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_run_r    <= 1'b0;
            rst_mirror_r <= 1'b0;
        end else begin
            // Clock keeps running through the reset-low phase of deactivation
            if (st_r == scs_pkg::SCS_DRST) begin
                if (tick && stop_end) clk_run_r <= 1'b0;
            end else if (!clk_zone) clk_run_r <= 1'b0;
            else if (!gated_r) clk_run_r <= in_act;
            else if (!s_host_reset_request || win_done) clk_run_r <= 1'b1;
            if (st_r != scs_pkg::SCS_ACTIVE || !sess_ok) rst_mirror_r <= 1'b0;
            else if (gated_r) rst_mirror_r <= win_done & s_host_reset_request;
            else rst_mirror_r <= s_host_reset_request;
        end
    end

    // ************************************************************
    // Card clock divider
    // ************************************************************
    logic [2:0] div_r;
    logic [1:0] dsel;
    logic       div_bit;
    assign dsel = {divider_select_hi, divider_select_lo};
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) div_r <= '0;
        else if (!clk_run_r) div_r <= '0; // Held so the divide-by-2/4/8 clocks start on a high phase; divide-by-1 follows the interface clock
        else if (tick) div_r <= div_r + 1'b1;
    end
    always_comb begin
        case (dsel)
            scs_pkg::DIV_8: div_bit = ~div_r[2];
            scs_pkg::DIV_4: div_bit = ~div_r[1];
            scs_pkg::DIV_2: div_bit = ~div_r[0];
            default:        div_bit = s_iclk;
        endcase
    end

    // ************************************************************
    // Level shifters: first side low drives
    // ************************************************************
    logic [2:0] own_host_r;
    logic [2:0] own_card_r;
    logic [2:0] idle_wait_r;
    logic [2:0] h_in;
    logic [2:0] c_in;
    logic       lines_en;
    assign h_in = {aux2_sync_r[1], s_ha1, s_hd};
    assign c_in = {aux2_sync_r[0], s_ca1, s_cd};
    assign lines_en = clk_zone || (st_r == scs_pkg::SCS_DRST) || (st_r == scs_pkg::SCS_DCLK);

    // Owner released when its own side goes high, then wait for both sides idle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            own_host_r  <= '0;
            own_card_r  <= '0;
            idle_wait_r <= '1;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!lines_en) begin
                    own_host_r[i]  <= 1'b0;
                    own_card_r[i]  <= 1'b0;
                    idle_wait_r[i] <= 1'b1;
                end else if (own_host_r[i] ? h_in[i] : (own_card_r[i] && c_in[i])) begin
                    own_host_r[i]  <= 1'b0;
                    own_card_r[i]  <= 1'b0;
                    idle_wait_r[i] <= 1'b1;
                end else if (idle_wait_r[i]) begin
                    idle_wait_r[i] <= !(h_in[i] && c_in[i]);
                end else if (!own_card_r[i]) begin
                    own_host_r[i] <= !h_in[i];
                    own_card_r[i] <= h_in[i] && !c_in[i];
                end
            end
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_n          <= 1'b0;
            card_supply_out <= 1'b0;
            card_clock_out  <= 1'b0;
            card_reset_out  <= 1'b0;
            host_data_out   <= 1'b0;
            host_data_oe    <= 1'b0;
            host_aux_one_out <= 1'b0;
            host_aux_one_oe <= 1'b0;
            host_aux_two_out <= 1'b0;
            host_aux_two_oe <= 1'b0;
            card_data_out   <= 1'b0;
            card_data_oe    <= 1'b1;
            card_aux_one_out <= 1'b0;
            card_aux_one_oe <= 1'b1;
            card_aux_two_out <= 1'b0;
            card_aux_two_oe <= 1'b1;
        end else begin
            flag_n          <= present_r & !fault;
            card_supply_out <= (st_r != scs_pkg::SCS_IDLE) && (st_r != scs_pkg::SCS_DOFF);
            card_clock_out  <= clk_run_r & div_bit;
            card_reset_out  <= rst_mirror_r;
            host_data_out   <= 1'b0;
            host_data_oe    <= own_card_r[0];
            host_aux_one_out <= 1'b0;
            host_aux_one_oe <= own_card_r[1];
            host_aux_two_out <= 1'b0;
            host_aux_two_oe <= own_card_r[2];
            // Card lines pulled low when not enabled, released high when idle
            card_data_out   <= 1'b0;
            card_data_oe    <= !lines_en | own_host_r[0];
            card_aux_one_out <= 1'b0;
            card_aux_one_oe <= !lines_en | own_host_r[1];
            card_aux_two_out <= 1'b0;
            card_aux_two_oe <= !lines_en | own_host_r[2];
        end
    end
endmodule
`default_nettype wire

// ---- scs_sequencer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic session_request_n,
    input wire logic card_detect_in,
    input wire logic detect_active_high,
    input wire logic host_uv_fault,
    input wire logic flag_n,
    input wire logic card_supply_out,
    input wire logic card_clock_out,
    input wire logic card_reset_out,
    input wire logic card_data_out,
    input wire logic card_data_oe,
    input wire logic card_aux_one_oe
);
    // ************************************************************
    // Sequencing and flag properties
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_clk_needs_supply: assert property (!card_supply_out |-> !card_clock_out)
        else $error("card clock runs without supply");
    a_rst_needs_supply: assert property (!card_supply_out |-> !card_reset_out)
        else $error("card reset high without supply");
    a_lines_low_off: assert property (!card_supply_out |-> card_data_oe && card_aux_one_oe)
        else $error("card lines released without supply");
    a_open_drain_low: assert property (card_data_out == 1'b0)
        else $error("card data driven high");
    a_absent_flag: assert property ((card_detect_in != detect_active_high) [*5] |-> !flag_n)
        else $error("flag high with no card");
    a_uv_flag_low: assert property (host_uv_fault [*5] |-> !flag_n)
        else $error("flag high under host undervoltage");
    a_supply_on_req: assert property ($rose(card_supply_out) |-> !$past(session_request_n))
        else $error("supply on without session request");
    a_release_rst: assert property (session_request_n [*5] |-> !card_reset_out)
        else $error("card reset high after session release");
    a_off_order: assert property ($fell(card_supply_out) |-> !card_clock_out && card_data_oe)
        else $error("supply off before clock and lines low");

    c_session: cover property ($rose(card_supply_out));
    c_clock: cover property ($rose(card_clock_out));
    c_reset: cover property ($rose(card_reset_out));
    c_flag: cover property ($rose(flag_n));
endmodule

bind scs_sequencer scs_sequencer_chk i_scs_sequencer_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .session_request_n(session_request_n),
    .card_detect_in(card_detect_in), .detect_active_high(detect_active_high),
    .host_uv_fault(host_uv_fault), .flag_n(flag_n), .card_supply_out(card_supply_out),
    .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
    .card_data_out(card_data_out), .card_data_oe(card_data_oe), .card_aux_one_oe(card_aux_one_oe)
);
`default_nettype wire

// ---- scs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
    input  wire logic sys_clk,
    input  wire logic open_cmd,
    input  wire logic reset_cmd,
    input  wire logic flag_n,
    output logic      session_request_n,
    output logic      host_reset_request
);
    // ************************************************************
    // Request drive
    // ************************************************************
    initial begin
        session_request_n = 1'b1;
        host_reset_request = 1'b0;
    end
    // Reset level set ahead of the session edge picks the mode
    always @(negedge sys_clk) host_reset_request <= reset_cmd;
    // Session opened only on presence, dropped on command
    always @(negedge sys_clk) begin
        if (!open_cmd) session_request_n <= 1'b1;
        else if (flag_n) session_request_n <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- test_smart_card_session_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_session_sequencer;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam int F = 7, S = 6, C = 5, R = 4, D = 3, H = 2;
    logic sys_clk = 1'b0, rst_b = 1'b0, ifc = 1'b0, sg = 1'b0, op = 1'b0, rq = 1'b0;
    logic det = 1'b0, dhi = 1'b0, dlo = 1'b0, uv = 1'b0, sf = 1'b0, rg = 1'b1, ot = 1'b0, dah = 1'b1;
    logic hd = 1'b0, cd = 1'b0, flag_n, card_supply_out, card_clock_out, card_reset_out, sreq_n, hrst;
    logic host_data_out, host_data_oe, host_aux_one_out, host_aux_one_oe, host_aux_two_out, host_aux_two_oe;
    logic card_data_out, card_data_oe, card_aux_one_out, card_aux_one_oe, card_aux_two_out, card_aux_two_oe;
    logic [7:0] mon;
    int bad_count = 0, total_checks = 0;
    assign mon = {flag_n, card_supply_out, card_clock_out, card_reset_out, card_data_oe, host_data_oe, 2'h0};
    // Clocks and supply sense
    always #2 sys_clk = ~sys_clk;
    always #8 ifc = ~ifc;
    always @(negedge sys_clk) sg <= card_supply_out;

    scs_sequencer #(.DEBOUNCE_CYCLES(20), .GATE_CYCLES(50), .STOP_CYCLES(10)) i_scs_sequencer (
        .sys_clk(sys_clk), .rst_b(rst_b), .interface_clock_in(ifc), .session_request_n(sreq_n),
        .host_reset_request(hrst), .card_detect_in(det), .detect_active_high(dah),
        .divider_select_hi(dhi), .divider_select_lo(dlo), .supply_good(sg), .host_uv_fault(uv),
        .supply_fault(sf), .regulator_input_supply(rg), .over_temp(ot),
        .host_data_in(~host_data_oe & ~hd), .host_aux_one_in(~host_aux_one_oe),
        .host_aux_two_in(~host_aux_two_oe), .card_data_in(~card_data_oe & ~cd),
        .card_aux_one_in(~card_aux_one_oe), .card_aux_two_in(~card_aux_two_oe), .flag_n(flag_n),
        .card_supply_out(card_supply_out), .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_aux_one_out(host_aux_one_out),
        .host_aux_one_oe(host_aux_one_oe), .host_aux_two_out(host_aux_two_out),
        .host_aux_two_oe(host_aux_two_oe), .card_data_out(card_data_out), .card_data_oe(card_data_oe),
        .card_aux_one_out(card_aux_one_out), .card_aux_one_oe(card_aux_one_oe),
        .card_aux_two_out(card_aux_two_out), .card_aux_two_oe(card_aux_two_oe));
    scs_host_model i_scs_host_model (.sys_clk(sys_clk), .open_cmd(op), .reset_cmd(rq), .flag_n(flag_n),
        .session_request_n(sreq_n), .host_reset_request(hrst));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Bounded wait on one monitored output
    task automatic wt(input string nm, input int b, input logic v, input int n, output int c);
        c = 0;
        while (mon[b] !== v) begin
            @(negedge sys_clk);
            c++;
            if (c > n) begin
                chk(nm, v, mon[b]);
                stop_test();
            end
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_presence();
        int c;
        chk("flag absent", 1'b0, flag_n);
        chk("card lines low", 1'b1, card_data_oe);
        chk("host pins free", 1'b0, host_data_oe);
        det = 1'b1;
        cyc(60);
        chk("debounce", 1'b0, flag_n);
        wt("flag present", F, 1'b1, 100, c);
        uv = 1'b1;
        wt("uv flag", F, 1'b0, 8, c);
        uv = 1'b0;
        wt("uv back", F, 1'b1, 120, c);
    endtask
    task automatic activate(input logic g);
        int c;
        rq = g;
        cyc(2);
        op = 1'b1;
        wt("supply on", S, 1'b1, 20, c);
        wt("lines on", D, 1'b0, 20, c);
        chk("clock idle", 1'b0, card_clock_out);
        if (g) begin
            cyc(20);
            chk("gated clock", 1'b0, card_clock_out);
            rq = 1'b0;
            wt("clock at fall", C, 1'b1, 12, c);
            rq = 1'b1;
            cyc(100);
            chk("gated reset", 1'b0, card_reset_out);
            wt("reset follows", R, 1'b1, 1200, c);
        end else begin
            wt("clock start", C, 1'b1, 700, c);
            chk("clock delay", 1'b1, c >= 460 && c <= 540);
            rq = 1'b1;
            wt("reset stage", R, 1'b1, 700, c);
            chk("reset delay", 1'b1, c >= 460 && c <= 540);
        end
    endtask
    task automatic t_data();
        int c;
        chk("aux lines free", 4'h0, {host_aux_one_oe, host_aux_two_oe, card_aux_one_oe, card_aux_two_oe});
        chk("drive levels", 6'h00, {host_data_out, host_aux_one_out, host_aux_two_out,
                                    card_data_out, card_aux_one_out, card_aux_two_out});
        hd = 1'b1;
        wt("card driven", D, 1'b1, 8, c);
        chk("host side free", 1'b0, host_data_oe);
        hd = 1'b0;
        wt("card freed", D, 1'b0, 8, c);
        cyc(4); // Channel back to idle before the card side pulls low
        cd = 1'b1;
        wt("host driven", H, 1'b1, 8, c);
        cd = 1'b0;
        wt("host freed", H, 1'b0, 8, c);
    endtask
    task automatic t_div();
        int c;
        int hx[4] = '{16, 8, 2, 4};
        for (int k = 0; k < 4; k++) begin
            {dhi, dlo} = 2'(k);
            cyc(80);
            wt("clock low", C, 1'b0, 40, c);
            wt("clock high", C, 1'b1, 40, c);
            wt("clock fall", C, 1'b0, 40, c);
            chk("clock half period", 1'b1, c >= hx[k] - 1 && c <= hx[k] + 1);
        end
    endtask
    task automatic deact();
        int c;
        op = 1'b0;
        wt("reset off", R, 1'b0, 10, c);
        cyc(10);
        wt("clock still runs", C, ~card_clock_out, 18, c);
        op = 1'b1;
        wt("supply off", S, 1'b0, 800, c);
        chk("lines off", 1'b1, card_data_oe);
        chk("aux lines off", 2'h3, {card_aux_one_oe, card_aux_two_oe});
        chk("clock off", 1'b0, card_clock_out);
        cyc(200);
        chk("no restart", 1'b0, card_supply_out);
        op = 1'b0;
        cyc(4);
    endtask
    task automatic t_faults();
        int c;
        for (int k = 0; k < 5; k++) begin
            activate(1'b0);
            case (k)
                0: ot = 1'b1;
                1: sf = 1'b1;
                2: uv = 1'b1;
                3: rg = 1'b0;
                default: det = 1'b0;
            endcase
            wt("fault flag", F, 1'b0, 8, c);
            wt("fault reset", R, 1'b0, 8, c);
            wt("fault off", S, 1'b0, 800, c);
            op = 1'b0;
            {ot, sf, uv, rg, det} = 5'h03;
            wt("flag again", F, 1'b1, 200, c);
        end
    endtask

    // Normally closed detect switch
    task automatic t_polarity();
        int c;
        dah = 1'b0;
        wt("closed switch absent", F, 1'b0, 8, c);
        det = 1'b0;
        cyc(40);
        chk("closed switch debounce", 1'b0, flag_n);
        wt("closed switch present", F, 1'b1, 200, c);
    endtask

    // Main sequence
    initial begin
        cyc(5);
        rst_b = 1'b1;
        cyc(3);
        t_presence();
        activate(1'b0);
        t_data();
        t_div();
        deact();
        activate(1'b1);
        deact();
        t_faults();
        t_polarity();
        stop_test();
    end
endmodule
`default_nettype wire
